//--- design/dasp_byte_lane.sv
`timescale 1ns/1ps
`default_nettype none
module dasp_byte_lane (
	input wire logic [15:0] rd_word_i,
	input wire logic [15:0] old_word_i,
	input wire logic [15:0] src_i,
	input wire logic high_i,
	input wire logic uns_i,
	output logic [15:0] load_o,
	output logic [15:0] store_o
);
	logic [7:0] sel;
	always_comb begin
		sel = high_i ? rd_word_i[15:8] : rd_word_i[7:0];
		load_o = uns_i ? {8'h00, sel} : {{8{sel[7]}}, sel};
		store_o = high_i ? {src_i[7:0], old_word_i[7:0]}
			: {old_word_i[15:8], src_i[7:0]};
	end
endmodule : dasp_byte_lane
`default_nettype wire

//--- design/dasp_pkg.sv
package dasp_pkg;
	localparam int WADDR_W = 23;
	localparam int BUS_W = 24;
	localparam int IOADDR_W = 16;
	localparam int PAGE_W = 7;
	localparam int PTR_W = 16;
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;
	localparam int VEC_W = 32;
	localparam int CFG_HI_POS = 29;
	localparam int CFG_LO_POS = 28;
	localparam logic [15:0] DSP_RST = 16'h0000;
	localparam logic [15:0] SYS_PTR_RST = 16'h0000;
	localparam logic [6:0] PAGE_RST = 7'h00;
	localparam logic [1:0] CFG_FAST_DUAL = 2'h0;
	localparam logic [1:0] CFG_SLOW_DUAL = 2'h1;
	localparam logic [1:0] CFG_SINGLE32 = 2'h2;
	typedef enum logic [1:0] {
		DASP_MMR_DSP,
		DASP_MMR_SYS,
		DASP_MMR_PAGE,
		DASP_MMR_NONE
	} dasp_mmr_t;
	typedef enum logic [2:0] {
		DASP_ACC_NONE,
		DASP_ACC_DATA,
		DASP_ACC_LONG_LSW,
		DASP_ACC_IO,
		DASP_ACC_DSTACK,
		DASP_ACC_SSTACK
	} dasp_acc_t;
endpackage : dasp_pkg

//--- design/dasp_top.sv
// Notes on behaviour
// - data words addressed by 23-bit word address
// - bus address is word address shifted left
// - byte load picks high or low byte
// - zero-extend when unsigned, else sign-extend
// - byte store replaces one byte only
// - long word partner address flips bit 0
// - io address 16 bits, zero-extended to 24
// - io reads on read bus, writes on write bus
// - data stack address is page joined pointer
// - data pointer predecrement push, postincrement pop
// - system stack same page, same push/pop rule
// - config from reset vector bits 29:28
// - 00 fast dual, 01 slow dual, 10 single
// - single stack moves system pointer along
// - dual stack: system pointer only on context
// - mapped data pointer write leaves system pointer
// - extended pointer write also sets page
// - extended pointers via instructions only
// - 128 pages of 64K, page joins offset
`timescale 1ns/1ps
`default_nettype none
module dasp_top (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [31:0] reset_vector_i,
	input wire logic vector_valid_i,
	input wire logic [2:0] acc_kind_i,
	input wire logic acc_write_i,
	input wire logic [22:0] word_addr_i,
	input wire logic [15:0] io_addr_i,
	input wire logic byte_high_i,
	input wire logic byte_uns_i,
	input wire logic [15:0] rd_word_i,
	input wire logic [15:0] src_i,
	input wire logic dstack_push_i,
	input wire logic dstack_pop_i,
	input wire logic ctx_push_i,
	input wire logic ctx_pop_i,
	input wire logic [1:0] mmr_sel_i,
	input wire logic mmr_we_i,
	input wire logic [15:0] mmr_wdata_i,
	input wire logic xdsp_we_i,
	input wire logic xsys_we_i,
	input wire logic [22:0] xptr_wdata_i,
	output logic [23:0] data_read_addr_bus_o,
	output logic data_read_valid_o,
	output logic [23:0] data_write_addr_bus_o,
	output logic data_write_valid_o,
	output logic [15:0] byte_load_o,
	output logic [15:0] byte_store_o,
	output logic [15:0] mmr_rdata_o,
	output logic [22:0] extended_data_stack_ptr_o,
	output logic [22:0] extended_system_stack_ptr_o,
	output logic [1:0] stack_cfg_o,
	output logic fast_return_o,
	output logic [23:0] reset_isr_addr_o
);
	logic [15:0] data_stack_pointer_r;
	logic [15:0] system_stack_pointer_r;
	logic [6:0] stack_page_field_r;
	logic [1:0] stack_cfg_r;
	logic [23:0] isr_addr_r;
	logic cfg_taken_r;
	logic [15:0] dsp_nxt;
	logic [15:0] sys_nxt;
	logic [22:0] rd_addr_nxt;
	logic [22:0] wr_addr_nxt;
	logic [23:0] bus_nxt;
	logic single_stack;
	logic dsp_step;
	logic sys_step;
	logic push_any;
	logic [15:0] dsp_eff;
	logic [15:0] sys_eff;

	// word address to bus: trailing zero
	function automatic logic [23:0] word_to_bus(input logic [22:0] a);
		return {a, 1'b0};
	endfunction : word_to_bus

	// wrap inside the 16-bit offset; the page never sees a carry
	function automatic logic [15:0] ptr_step(input logic [15:0] p,
		input logic dec);
		return dec ? p - 16'h0001 : p + 16'h0001;
	endfunction : ptr_step

	assign single_stack = (stack_cfg_r == dasp_pkg::CFG_SINGLE32);
	assign push_any = dstack_push_i | ctx_push_i;
	assign dsp_step = dstack_push_i | dstack_pop_i | ctx_push_i | ctx_pop_i;
	// system pointer moves on context save/restore, or with data pointer in single-stack mode
	assign sys_step = ctx_push_i | ctx_pop_i |
		(single_stack & (dstack_push_i | dstack_pop_i));
	// pushes address the predecremented slot, pops the current one
	assign dsp_eff = push_any ? ptr_step(data_stack_pointer_r, 1'b1)
		: data_stack_pointer_r;
	assign sys_eff = push_any ? ptr_step(system_stack_pointer_r, 1'b1)
		: system_stack_pointer_r;

	always_comb begin
		dsp_nxt = data_stack_pointer_r;
		if (dsp_step)
			dsp_nxt = ptr_step(data_stack_pointer_r, push_any);
		sys_nxt = system_stack_pointer_r;
		if (sys_step)
			sys_nxt = ptr_step(system_stack_pointer_r, push_any);
	end

	// pointers: mapped writes lose to a stack step in the same cycle
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			data_stack_pointer_r <= dasp_pkg::DSP_RST;
			system_stack_pointer_r <= dasp_pkg::SYS_PTR_RST;
		end else if (xdsp_we_i || xsys_we_i) begin
			if (xdsp_we_i)
				data_stack_pointer_r <= xptr_wdata_i[15:0];
			if (xsys_we_i)
				system_stack_pointer_r <= xptr_wdata_i[15:0];
		end else if (dsp_step || sys_step) begin
			data_stack_pointer_r <= dsp_nxt;
			system_stack_pointer_r <= sys_nxt;
		end else if (mmr_we_i) begin
			// mapped data pointer write never touches the system one
			if (mmr_sel_i == 2'(dasp_pkg::DASP_MMR_DSP))
				data_stack_pointer_r <= mmr_wdata_i;
			if (mmr_sel_i == 2'(dasp_pkg::DASP_MMR_SYS))
				system_stack_pointer_r <= mmr_wdata_i;
		end
	end

	// page field: only writes change it, stack traffic never does
	always_ff @(posedge clock_i) begin
		if (rst_i)
			stack_page_field_r <= dasp_pkg::PAGE_RST;
		else if (xdsp_we_i || xsys_we_i)
			stack_page_field_r <= xptr_wdata_i[22:16];
		else if (mmr_we_i && mmr_sel_i == 2'(dasp_pkg::DASP_MMR_PAGE))
			stack_page_field_r <= mmr_wdata_i[6:0];
	end

	// configuration is latched once, from the first vector after reset
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			stack_cfg_r <= dasp_pkg::CFG_FAST_DUAL;
			isr_addr_r <= 24'h000000;
			cfg_taken_r <= 1'b0;
		end else if (!cfg_taken_r && vector_valid_i) begin
			stack_cfg_r <= reset_vector_i[dasp_pkg::CFG_HI_POS:
				dasp_pkg::CFG_LO_POS];
			isr_addr_r <= reset_vector_i[23:0];
			cfg_taken_r <= 1'b1;
		end
	end

	// address selection for this cycle
	always_comb begin
		rd_addr_nxt = word_addr_i;
		case (acc_kind_i)
			3'(dasp_pkg::DASP_ACC_LONG_LSW):
				rd_addr_nxt = {word_addr_i[22:1], ~word_addr_i[0]};
			3'(dasp_pkg::DASP_ACC_DSTACK):
				rd_addr_nxt = {stack_page_field_r, dsp_eff};
			3'(dasp_pkg::DASP_ACC_SSTACK):
				rd_addr_nxt = {stack_page_field_r, sys_eff};
			default:
				rd_addr_nxt = word_addr_i;
		endcase
		wr_addr_nxt = rd_addr_nxt;
		if (acc_kind_i == 3'(dasp_pkg::DASP_ACC_IO))
			bus_nxt = {8'h00, io_addr_i};
		else
			bus_nxt = word_to_bus(wr_addr_nxt);
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			data_read_addr_bus_o <= 24'h000000;
			data_read_valid_o <= 1'b0;
			data_write_addr_bus_o <= 24'h000000;
			data_write_valid_o <= 1'b0;
		end else begin
			data_read_valid_o <= 1'b0;
			data_write_valid_o <= 1'b0;
			if (acc_kind_i != 3'(dasp_pkg::DASP_ACC_NONE)) begin
				if (acc_write_i) begin
					data_write_addr_bus_o <= bus_nxt;
					data_write_valid_o <= 1'b1;
				end else begin
					data_read_addr_bus_o <= bus_nxt;
					data_read_valid_o <= 1'b1;
				end
			end
		end
	end

	logic [15:0] load_c;
	logic [15:0] store_c;
	dasp_byte_lane u_lane (
		.rd_word_i(rd_word_i),
		.old_word_i(rd_word_i),
		.src_i(src_i),
		.high_i(byte_high_i),
		.uns_i(byte_uns_i),
		.load_o(load_c),
		.store_o(store_c)
	);

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			byte_load_o <= 16'h0000;
			byte_store_o <= 16'h0000;
		end else begin
			byte_load_o <= load_c;
			byte_store_o <= store_c;
		end
	end

	always_comb begin
		case (mmr_sel_i)
			2'(dasp_pkg::DASP_MMR_DSP): mmr_rdata_o = data_stack_pointer_r;
			2'(dasp_pkg::DASP_MMR_SYS): mmr_rdata_o = system_stack_pointer_r;
			2'(dasp_pkg::DASP_MMR_PAGE):
				mmr_rdata_o = {9'h000, stack_page_field_r};
			default: mmr_rdata_o = 16'h0000;
		endcase
	end

	// extended pointers exist only as instruction-side ports
	assign extended_data_stack_ptr_o =
		{stack_page_field_r, data_stack_pointer_r};
	assign extended_system_stack_ptr_o =
		{stack_page_field_r, system_stack_pointer_r};
	assign stack_cfg_o = stack_cfg_r;
	assign fast_return_o = (stack_cfg_r == dasp_pkg::CFG_FAST_DUAL);
	assign reset_isr_addr_o = isr_addr_r;

	a_ptr_wrap: assert property (@(posedge clock_i) disable iff (rst_i)
		dstack_push_i && !dstack_pop_i && !ctx_push_i && !ctx_pop_i &&
		!xdsp_we_i && !xsys_we_i && data_stack_pointer_r == 16'h0000
		|=> data_stack_pointer_r == 16'hFFFF &&
		$stable(stack_page_field_r))
		else $error("data pointer did not wrap in page");
	a_single_link: assert property (@(posedge clock_i) disable iff (rst_i)
		single_stack && dstack_pop_i && !dstack_push_i && !ctx_push_i &&
		!xdsp_we_i && !xsys_we_i
		|=> system_stack_pointer_r == $past(system_stack_pointer_r) + 16'h0001)
		else $error("system pointer not linked in single stack");
	a_dual_indep: assert property (@(posedge clock_i) disable iff (rst_i)
		!single_stack && !ctx_push_i && !ctx_pop_i && !xsys_we_i &&
		!(mmr_we_i && mmr_sel_i == 2'(dasp_pkg::DASP_MMR_SYS))
		|=> $stable(system_stack_pointer_r))
		else $error("system pointer moved in dual stack");
	a_mmr_noalign: assert property (@(posedge clock_i) disable iff (rst_i)
		mmr_we_i && mmr_sel_i == 2'(dasp_pkg::DASP_MMR_DSP) && !dsp_step &&
		!sys_step && !xdsp_we_i && !xsys_we_i
		|=> $stable(system_stack_pointer_r) &&
		data_stack_pointer_r == $past(mmr_wdata_i))
		else $error("mapped write misbehaved");
	a_xptr_page: assert property (@(posedge clock_i) disable iff (rst_i)
		xsys_we_i |=> stack_page_field_r == $past(xptr_wdata_i[22:16]))
		else $error("page not set by extended write");
	a_bus_shift: assert property (@(posedge clock_i) disable iff (rst_i)
		acc_kind_i == 3'(dasp_pkg::DASP_ACC_DATA) && !acc_write_i
		|=> data_read_valid_o && data_read_addr_bus_o[0] == 1'b0 &&
		data_read_addr_bus_o[23:1] == $past(word_addr_i))
		else $error("data read address not shifted");
	a_io_write: assert property (@(posedge clock_i) disable iff (rst_i)
		acc_kind_i == 3'(dasp_pkg::DASP_ACC_IO) && acc_write_i
		|=> data_write_valid_o && !data_read_valid_o &&
		data_write_addr_bus_o == {8'h00, $past(io_addr_i)})
		else $error("io write address wrong");
	a_cfg_hold: assert property (@(posedge clock_i) disable iff (rst_i)
		cfg_taken_r |=> $stable(stack_cfg_r))
		else $error("stack configuration changed after capture");
endmodule : dasp_top
`default_nettype wire

//--- dv/dasp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dasp_mem_model (
	input wire logic clock_i,
	input wire logic [23:0] rd_addr_i,
	input wire logic rd_valid_i,
	output logic [15:0] rd_word_o
);
	logic [15:0] last_r = 16'h5A5A;
	always @(posedge clock_i) begin
		if (rd_valid_i) begin
			last_r <= rd_word_o;
		end
	end
	// released bus shows the inverse, so a stale word never passes
	always_comb begin
		if (rd_valid_i) begin
			rd_word_o = {rd_addr_i[8:1], rd_addr_i[8:1] | 8'h80};
		end else begin
			rd_word_o = ~last_r;
		end
	end
endmodule : dasp_mem_model
`default_nettype wire

//--- dv/test_data_address_and_stack_pointers.sv
`timescale 1ns/1ps
`default_nettype none
module test_data_address_and_stack_pointers;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [31:0] reset_vector_i = 32'h0;
	logic [2:0] acc_kind_i = 3'h0;
	logic [22:0] word_addr_i = 23'h0;
	logic [22:0] xptr_wdata_i = 23'h0;
	logic [15:0] io_addr_i = 16'h0;
	logic [15:0] src_i = 16'h0;
	logic [15:0] mmr_wdata_i = 16'h0;
	logic [1:0] mmr_sel_i = 2'h3;
	logic vector_valid_i = 1'b0;
	logic acc_write_i = 1'b0;
	logic byte_high_i = 1'b0;
	logic byte_uns_i = 1'b0;
	logic dstack_push_i = 1'b0;
	logic dstack_pop_i = 1'b0;
	logic ctx_push_i = 1'b0;
	logic ctx_pop_i = 1'b0;
	logic mmr_we_i = 1'b0;
	logic xdsp_we_i = 1'b0;
	logic xsys_we_i = 1'b0;
	logic [15:0] rd_word_i, byte_load_o, byte_store_o, mmr_rdata_o;
	logic [23:0] data_read_addr_bus_o, data_write_addr_bus_o;
	logic [23:0] reset_isr_addr_o;
	logic data_read_valid_o, data_write_valid_o, fast_return_o;
	logic [22:0] extended_data_stack_ptr_o, extended_system_stack_ptr_o;
	logic [1:0] stack_cfg_o;
	int mismatches = 0;
	int total_checks = 0;
	always #4 clock_i = ~clock_i;
	dasp_top dut_u (.clock_i, .rst_i, .reset_vector_i, .vector_valid_i,
		.acc_kind_i, .acc_write_i, .word_addr_i, .io_addr_i, .byte_high_i,
		.byte_uns_i, .rd_word_i, .src_i, .dstack_push_i, .dstack_pop_i,
		.ctx_push_i, .ctx_pop_i, .mmr_sel_i, .mmr_we_i, .mmr_wdata_i,
		.xdsp_we_i, .xsys_we_i, .xptr_wdata_i, .data_read_addr_bus_o,
		.data_read_valid_o, .data_write_addr_bus_o, .data_write_valid_o,
		.byte_load_o, .byte_store_o, .mmr_rdata_o, .extended_data_stack_ptr_o,
		.extended_system_stack_ptr_o, .stack_cfg_o, .fast_return_o,
		.reset_isr_addr_o);
	dasp_mem_model mem_u (.clock_i, .rd_addr_i(data_read_addr_bus_o),
		.rd_valid_i(data_read_valid_o), .rd_word_o(rd_word_i));
	task automatic chk(input string nm, input logic [23:0] e,
		input logic [23:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge clock_i);
	endtask : tick
	task automatic acc(input logic [2:0] k, input logic w,
		input logic [22:0] a, input logic [15:0] io);
		acc_kind_i = k;
		acc_write_i = w;
		word_addr_i = a;
		io_addr_i = io;
		tick(1);
		acc_kind_i = 3'h0;
	endtask : acc
	task automatic mmr(input logic [1:0] s, input logic [15:0] d);
		mmr_sel_i = s;
		mmr_wdata_i = d;
		mmr_we_i = 1'b1;
		tick(1);
		mmr_we_i = 1'b0;
	endtask : mmr
	task automatic boot(input logic [1:0] c);
		rst_i = 1'b1;
		vector_valid_i = 1'b0;
		tick(3);
		chk("cfg rst", 24'h0, {22'h0, stack_cfg_o});
		chk("fast rst", 24'h1, {23'h0, fast_return_o});
		chk("xdsp rst", 24'h0, {1'b0, extended_data_stack_ptr_o});
		rst_i = 1'b0;
		reset_vector_i = {2'h1, c, 4'hA, 24'h1234AB};
		vector_valid_i = 1'b1;
		tick(1);
		// config must stay frozen though the vector changes
		reset_vector_i = 32'h0;
		tick(1);
		chk("cfg", {22'h0, c}, {22'h0, stack_cfg_o});
		chk("fast", {23'h0, c == 2'h0}, {23'h0, fast_return_o});
		chk("isr", 24'h1234AB, reset_isr_addr_o);
	endtask : boot
	task automatic t_addr;
		acc(3'h1, 1'b0, 23'h000102, 16'h0);
		chk("rd word", 24'h000204, data_read_addr_bus_o);
		chk("rd vld", 24'h1, {23'h0, data_read_valid_o});
		acc(3'h1, 1'b1, 23'h7FFFFF, 16'h0);
		chk("wr word", 24'hFFFFFE, data_write_addr_bus_o);
		chk("rd drop", 24'h0, {23'h0, data_read_valid_o});
		chk("wr vld", 24'h1, {23'h0, data_write_valid_o});
		acc(3'h2, 1'b0, 23'h000105, 16'h0);
		chk("lsw odd", 24'h000208, data_read_addr_bus_o);
		acc(3'h2, 1'b1, 23'h000102, 16'h0);
		chk("lsw even", 24'h000206, data_write_addr_bus_o);
		acc(3'h3, 1'b0, 23'h7FFFFF, 16'h0102);
		chk("io rd", 24'h000102, data_read_addr_bus_o);
		acc(3'h3, 1'b1, 23'h0, 16'hFFFF);
		chk("io wr", 24'h00FFFF, data_write_addr_bus_o);
		$display("test addr done");
	endtask : t_addr
	task automatic t_byte;
		logic [15:0] ld [4] = '{16'hFF85, 16'h0085, 16'h0005, 16'h0005};
		src_i = 16'h12AB;
		for (int i = 0; i < 4; i++) begin
			byte_high_i = i[1];
			byte_uns_i = i[0];
			acc(3'h1, 1'b0, 23'h000005, 16'h0);
			tick(1);
			chk("load", {8'h0, ld[i]}, {8'h0, byte_load_o});
			chk("store", i[1] ? 24'hAB85 : 24'h05AB, {8'h0, byte_store_o});
		end
		$display("test byte done");
	endtask : t_byte
	task automatic t_stack(input logic [1:0] c);
		logic [15:0] sd;
		boot(c);
		sd = (c == 2'h2) ? 16'hFFFF : 16'h0000;
		mmr(2'h2, 16'h0005);
		mmr(2'h1, 16'h0010);
		dstack_push_i = 1'b1;
		acc(3'h4, 1'b1, 23'h0, 16'h0);
		dstack_push_i = 1'b0;
		chk("push bus", 24'h0BFFFE, data_write_addr_bus_o);
		chk("push dsp", 24'h05FFFF, {1'b0, extended_data_stack_ptr_o});
		chk("push sys", {8'h05, 16'h0010 + sd},
			{1'b0, extended_system_stack_ptr_o});
		dstack_pop_i = 1'b1;
		acc(3'h4, 1'b0, 23'h0, 16'h0);
		dstack_pop_i = 1'b0;
		chk("pop bus", 24'h0BFFFE, data_read_addr_bus_o);
		chk("pop dsp", 24'h050000, {1'b0, extended_data_stack_ptr_o});
		chk("pop sys", 24'h050010, {1'b0, extended_system_stack_ptr_o});
		ctx_push_i = 1'b1;
		acc(3'h5, 1'b1, 23'h0, 16'h0);
		ctx_push_i = 1'b0;
		chk("ctx bus", 24'h0A001E, data_write_addr_bus_o);
		chk("ctx sys", 24'h05000F, {1'b0, extended_system_stack_ptr_o});
		mmr(2'h0, 16'h1234);
		chk("mmr dsp", 24'h1234, {8'h0, mmr_rdata_o});
		chk("mmr sys", 24'h05000F, {1'b0, extended_system_stack_ptr_o});
		xptr_wdata_i = 23'h7A0042;
		xdsp_we_i = 1'b1;
		mmr(2'h2, 16'h0011);
		xdsp_we_i = 1'b0;
		chk("page", 24'h7A, {8'h0, mmr_rdata_o});
		chk("x sys", 24'h7A000F, {1'b0, extended_system_stack_ptr_o});
		$display("test stack cfg %0d done", c);
	endtask : t_stack
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize
	initial begin
		tick(1);
		boot(2'h0);
		t_addr;
		t_byte;
		for (int c = 0; c < 3; c++) begin
			t_stack(c[1:0]);
		end
		summarize;
	end
endmodule : test_data_address_and_stack_pointers
`default_nettype wire
